// ===== src/touch_acq_global_setups.sv
// Functional notes
// - selected key's burst drives a positive sync pulse across the whole burst
// - selector 0-23 picks one key, 24-31 disables; default 24
// - reference below lower limit flags key error and device status error
// - lower limit is 11 bits, low byte 242, high bits 243, default 100
// - gain test passes only if normal minus half-burst sample exceeds threshold
// - gain threshold index 0-15 maps to 4..64; default index 6 gives 28
// - dwell 0-7 sets capture time 125 ns to 4.5 us; default 0
// - burst yields to host traffic; pause is registered, so both run in the first overlap cycle
// - restart flag set: burst interrupted by host traffic restarts from start
// - restart flag clear: interrupted burst completes without restart
// - key detect threshold equals key threshold times global multiplier
// - multiplier code 0..3 gives x1, x2, x4, x8; default 0
// - effective ranges 4-18, 8-36, 16-72, 32-144
// - hop field disables hopping or selects one of three modes
// - hop codes off, recal, adjust, sweep; default 3
`timescale 1ns/1ns
`default_nettype none
`include "touch_acq_defines.svh"
module touch_acq_global_setups
   import touch_acq_pkg::*;
#(
   parameter int KEYS = `KEY_COUNT
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [7:0]        setupAddr,
   input  wire logic [7:0]        setupWrData,
   input  wire logic              setupWr,
   input  wire logic              setupRd,
   output logic      [7:0]        setupRdData,
   output logic                   setupRdHit,
   input  wire logic              burstActive,
   input  wire logic [4:0]        burstKey,
   input  wire logic              hostBusy,
   output logic                   burstPause,
   output logic                   burstRestart,
   output logic                   syncPulse,
   input  wire key_sample_s       refSample,
   output logic      [KEYS-1:0]   keyLimitError,
   output logic                   statusLimitError,
   input  wire logic              statusClear,
   input  wire key_sample_s       testSample,
   input  wire logic [10:0]       normalSignal,
   output logic      [KEYS-1:0]   gainPass,
   input  wire logic [4:0]        keyThreshold,
   output logic      [7:0]        detectThreshold,
   output logic      [6:0]        dwellCycles,
   output hop_mode_e              hopMode,
   output setup_s                 setups
);
   // ==========================================
   // setup storage
   logic [7:0]  scopeSync;
   logic [7:0]  limitLow;
   logic [7:0]  gainLimit;
   logic [7:0]  acqTiming;
   logic        interrupted;
   logic [6:0]  gainThr;
   logic [11:0] gainDiff;
   setup_s      next_setups;

   always_comb begin
      next_setups.positiveDriftRate       = scopeSync[2:0];
      next_setups.scopeSyncKeySelect      = scopeSync[`SYNC_SEL_LSB +: 5];
      next_setups.lowerSignalLimit        = {gainLimit[`LIMIT_HI_LSB +: 3], limitLow};
      next_setups.gainTestThreshold       = gainLimit[`GAIN_IDX_LSB +: 4];
      next_setups.dwell                   = acqTiming[`DWELL_LSB +: 3];
      next_setups.restartInterruptedBurst = acqTiming[`RESTART_BIT];
      next_setups.thresholdMultiplier     = acqTiming[`MULT_LSB +: 2];
      next_setups.hopMode                 = hop_mode_e'(acqTiming[`HOP_LSB +: 2]);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scopeSync <= `RST_SCOPE_SYNC;
         limitLow  <= `RST_LIMIT_LOW;
         gainLimit <= `RST_GAIN_LIMIT;
         acqTiming <= `RST_ACQ_TIMING;
      end else if (setupWr) begin
         unique case (setupAddr)
            `ADDR_SCOPE_SYNC: scopeSync <= setupWrData;
            `ADDR_LIMIT_LOW:  limitLow  <= setupWrData;
            `ADDR_GAIN_LIMIT: gainLimit <= setupWrData & 8'hF7;
            `ADDR_ACQ_TIMING: acqTiming <= setupWrData;
            default: ;
         endcase
      end
   end

   // unused bit 3 of byte 243 reads zero; other addresses answer zero, no hit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setupRdData <= 8'h00;
         setupRdHit  <= 1'b0;
      end else begin
         setupRdHit <= 1'b0;
         if (setupRd) begin
            setupRdHit <= 1'b1;
            unique case (setupAddr)
               `ADDR_SCOPE_SYNC: setupRdData <= scopeSync;
               `ADDR_LIMIT_LOW:  setupRdData <= limitLow;
               `ADDR_GAIN_LIMIT: setupRdData <= gainLimit;
               `ADDR_ACQ_TIMING: setupRdData <= acqTiming;
               default: begin
                  setupRdData <= 8'h00;
                  setupRdHit  <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setups  <= '0;
         hopMode <= HOP_OFF;
      end else begin
         setups  <= next_setups;
         hopMode <= next_setups.hopMode;
      end
   end

   // ==========================================
   // scope sync
   // the pulse shares its pin with the change line; leaving it on corrupts both
   // pulse over selected burst
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         syncPulse <= 1'b0;
      end else begin
         syncPulse <= burstActive && (next_setups.scopeSyncKeySelect < `SYNC_OFF_MIN)
                      && (burstKey == next_setups.scopeSyncKeySelect);
      end
   end

   // ==========================================
   // lower signal limit check
   // per key and device error
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         keyLimitError    <= '0;
         statusLimitError <= 1'b0;
      end else begin
         if (statusClear) begin
            keyLimitError    <= '0;
            statusLimitError <= 1'b0;
         end
         // a new error in the clear cycle wins over the clear
         if (refSample.valid && refSample.key < KEYS
             && refSample.value < next_setups.lowerSignalLimit) begin
            keyLimitError[refSample.key] <= 1'b1;
            statusLimitError             <= 1'b1;
         end
      end
   end

   // ==========================================
   // key gain test
   // linear lookup 4 + 4*index
   assign gainThr  = `GAIN_THR_BASE + 7'(next_setups.gainTestThreshold) * `GAIN_THR_STEP;
   assign gainDiff = {1'b0, normalSignal} - {1'b0, testSample.value};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gainPass <= '0;
      end else if (testSample.valid && testSample.key < KEYS) begin
         gainPass[testSample.key] <= !gainDiff[11] && (gainDiff[10:0] > 11'(gainThr));
      end
   end

   // ==========================================
   // detect threshold and dwell
   // power of two multiplier
   // 18 x8 fits in 8 bits
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         detectThreshold <= 8'h00;
      end else begin
         detectThreshold <= 8'({3'b000, keyThreshold} << next_setups.thresholdMultiplier);
      end
   end

   // dwell time in ns rounded up to whole clock cycles
   function automatic logic [6:0] dwell_cycles(input logic [2:0] code);
      int ns;
      ns = `DWELL_BASE_NS + `DWELL_STEP_NS * int'(code);
      return 7'((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dwellCycles <= 7'h03;
      end else begin
         dwellCycles <= dwell_cycles(next_setups.dwell);
      end
   end

   // ==========================================
   // burst versus host traffic
   // host traffic wins from the second overlap cycle on; the burst engine holds while paused
   // pause burst during host
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         burstPause <= 1'b0;
      end else begin
         burstPause <= burstActive && hostBusy;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         interrupted  <= 1'b0;
         burstRestart <= 1'b0;
      end else begin
         burstRestart <= 1'b0;
         if (burstActive && hostBusy) begin
            interrupted <= 1'b1;
         end else if (!hostBusy) begin
            interrupted <= 1'b0;
            if (interrupted && burstActive && next_setups.restartInterruptedBurst) begin
               burstRestart <= 1'b1;
            end
         end
      end
   end

   // ==========================================
   // checks
   a_sync_follows: assert property (@(posedge clk) disable iff (!nrst)
      (burstActive && burstKey == scopeSync[7:3] && scopeSync[7:3] < 5'h18
       && !setupWr) |=> syncPulse)
      else $error("sync pulse missing on selected burst");
   a_sync_off: assert property (@(posedge clk) disable iff (!nrst)
      (scopeSync[7:3] >= 5'h18 && $stable(scopeSync)) |=> !syncPulse)
      else $error("sync pulse while selector off");
   a_limit_error: assert property (@(posedge clk) disable iff (!nrst)
      (refSample.valid && refSample.key < KEYS
       && refSample.value < {gainLimit[2:0], limitLow})
      |=> statusLimitError && keyLimitError[$past(refSample.key)])
      else $error("limit error not flagged");
   a_limit_reset: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> {gainLimit[2:0], limitLow} == 11'd100)
      else $error("lower limit default wrong");
   a_gain_pass: assert property (@(posedge clk) disable iff (!nrst)
      (testSample.valid && testSample.key < KEYS && gainLimit[7:4] == 4'h6
       && normalSignal == testSample.value + 11'd28)
      |=> !gainPass[$past(testSample.key)])
      else $error("gain test passed at equal threshold");
   a_dwell_max: assert property (@(posedge clk) disable iff (!nrst)
      (acqTiming[2:0] == 3'h7) |=> dwellCycles == 7'd90)
      else $error("dwell 7 not 4.5 us");
   a_no_overlap: assert property (@(posedge clk) disable iff (!nrst)
      (burstActive && hostBusy) [*2] |-> burstPause)
      else $error("burst not paused for host");
   a_restart_pulse: assert property (@(posedge clk) disable iff (!nrst)
      (interrupted && !hostBusy && burstActive && acqTiming[3]) |=> burstRestart)
      else $error("interrupted burst not restarted");
   a_no_restart: assert property (@(posedge clk) disable iff (!nrst)
      (!acqTiming[3] && $stable(acqTiming)) |=> !burstRestart)
      else $error("restart with flag clear");
   a_thr_mult: assert property (@(posedge clk) disable iff (!nrst)
      (acqTiming[5:4] == 2'h3 && keyThreshold == 5'd18) |=> detectThreshold == 8'd144)
      else $error("x8 threshold wrong");
   a_hop_default: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) ##1 !setupWr |-> ##1 hopMode == HOP_SWEEP || $past(setupWr))
      else $error("hop mode default not sweep");
   a_sync_burst_end: assert property (@(posedge clk) disable iff (!nrst)
      !burstActive |=> !syncPulse)
      else $error("sync pulse outside a burst");
   a_gain_pass_max: assert property (@(posedge clk) disable iff (!nrst)
      (testSample.valid && testSample.key < KEYS && gainLimit[7:4] == 4'hF
       && testSample.value < 11'd1983 && normalSignal == testSample.value + 11'd65)
      |=> gainPass[$past(testSample.key)])
      else $error("gain test failed above top threshold");
   a_mult_unity: assert property (@(posedge clk) disable iff (!nrst)
      (acqTiming[5:4] == 2'h0) |=> detectThreshold == {3'b000, $past(keyThreshold)})
      else $error("x1 threshold wrong");
   a_thr_range_low: assert property (@(posedge clk) disable iff (!nrst)
      (acqTiming[5:4] == 2'h3 && keyThreshold == 5'd4) |=> detectThreshold == 8'd32)
      else $error("x8 low threshold wrong");
   a_hop_follows: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> hopMode == $past(acqTiming[7:6]))
      else $error("hop mode not taken from setup");
   a_read_unmapped: assert property (@(posedge clk) disable iff (!nrst)
      (setupRd && (setupAddr < 8'hF1 || setupAddr > 8'hF4)) |=> !setupRdHit && setupRdData == 8'h00)
      else $error("unmapped read answered");
   a_restart_once: assert property (@(posedge clk) disable iff (!nrst)
      burstRestart |=> !burstRestart)
      else $error("restart pulse longer than one cycle");
endmodule
`default_nettype wire

// ===== pkg/touch_acq_defines.svh
`ifndef TOUCH_ACQ_DEFINES_SVH
`define TOUCH_ACQ_DEFINES_SVH
// ==========================================
// setup addresses
`define ADDR_SCOPE_SYNC   8'hF1
`define ADDR_LIMIT_LOW    8'hF2
`define ADDR_GAIN_LIMIT   8'hF3
`define ADDR_ACQ_TIMING   8'hF4
// ==========================================
// reset values
`define RST_SCOPE_SYNC    8'hC0
`define RST_LIMIT_LOW     8'h64
`define RST_GAIN_LIMIT    8'h60
`define RST_ACQ_TIMING    8'hC0
// ==========================================
// field positions
`define SYNC_SEL_LSB      3
`define LIMIT_HI_LSB      0
`define GAIN_IDX_LSB      4
`define DWELL_LSB         0
`define RESTART_BIT       3
`define MULT_LSB          4
`define HOP_LSB           6
// ==========================================
// limits and lookup figures
`define SYNC_OFF_MIN      5'h18
`define KEY_COUNT         24
`define GAIN_THR_BASE     7'h04
`define GAIN_THR_STEP     7'h04
`define CLK_PERIOD_NS     50
`define DWELL_BASE_NS     125
`define DWELL_STEP_NS     625
`endif

// ===== pkg/touch_acq_pkg.sv
`default_nettype none
package touch_acq_pkg;
   // ==========================================
   // hopping modes
   typedef enum logic [1:0] {
      HOP_OFF   = 2'b00,
      HOP_RECAL = 2'b01,
      HOP_ADJ   = 2'b10,
      HOP_SWEEP = 2'b11
   } hop_mode_e;

   // ==========================================
   // decoded global setups
   typedef struct packed {
      hop_mode_e   hopMode;
      logic [1:0]  thresholdMultiplier;
      logic        restartInterruptedBurst;
      logic [2:0]  dwell;
      logic [3:0]  gainTestThreshold;
      logic [10:0] lowerSignalLimit;
      logic [4:0]  scopeSyncKeySelect;
      logic [2:0]  positiveDriftRate;
   } setup_s;

   // ==========================================
   // one key measurement from the acquisition engine
   typedef struct packed {
      logic        valid;
      logic [4:0]  key;
      logic [10:0] value;
   } key_sample_s;
endpackage
`default_nettype wire

// ===== sim/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic       clk,
   input  wire logic [7:0] setupRdData,
   input  wire logic       setupRdHit,
   output logic      [7:0] setupAddr,
   output logic      [7:0] setupWrData,
   output logic            setupWr,
   output logic            setupRd,
   output logic            hostBusy
);
   // ==========================================
   // idle bus
   initial begin
      setupAddr = 8'h00;
      setupWrData = 8'h00;
      setupWr = 1'b0;
      setupRd = 1'b0;
      hostBusy = 1'b0;
   end
   // ==========================================
   // setup writes and reads, one strobe cycle each
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      setupAddr = a;
      setupWrData = d;
      setupWr = 1'b1;
      @(negedge clk);
      setupWr = 1'b0;
      // released lines show the inverse so a stale value cannot pass
      setupAddr = ~a;
      setupWrData = ~d;
   endtask
   task automatic get(input logic [7:0] a, output logic [7:0] d, output logic hit);
      @(negedge clk);
      setupAddr = a;
      setupRd = 1'b1;
      @(negedge clk);
      d = setupRdData;
      hit = setupRdHit;
      setupRd = 1'b0;
      setupAddr = ~a;
   endtask
   // ==========================================
   // serial traffic window
   task automatic traffic(input int cycles);
      @(negedge clk);
      hostBusy = 1'b1;
      repeat (cycles) @(negedge clk);
      hostBusy = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/touch_acq_global_setups_test.sv
`timescale 1ns/1ns
`default_nettype none
module touch_acq_global_setups_test
   import touch_acq_pkg::*;
;
   logic clk, nrst, setupWr, setupRd, setupRdHit, burstActive, hostBusy, burstPause, burstRestart, syncPulse;
   logic [7:0]  setupAddr, setupWrData, setupRdData, detectThreshold;
   logic [4:0]  burstKey, keyThreshold;
   logic [23:0] keyLimitError, gainPass;
   logic        statusLimitError, statusClear;
   logic [10:0] normalSignal;
   logic [6:0]  dwellCycles;
   hop_mode_e   hopMode;
   setup_s      setups;
   key_sample_s refSample, testSample;
   int          failures, testsRun, seen;
   logic [2:0]  c;
   logic [6:0]  thr;

   touch_acq_global_setups u_touch_acq_global_setups (.clk(clk), .nrst(nrst), .setupAddr(setupAddr),
      .setupWrData(setupWrData), .setupWr(setupWr), .setupRd(setupRd), .setupRdData(setupRdData),
      .setupRdHit(setupRdHit), .burstActive(burstActive), .burstKey(burstKey), .hostBusy(hostBusy),
      .burstPause(burstPause), .burstRestart(burstRestart), .syncPulse(syncPulse), .refSample(refSample),
      .keyLimitError(keyLimitError), .statusLimitError(statusLimitError), .statusClear(statusClear),
      .testSample(testSample), .normalSignal(normalSignal), .gainPass(gainPass), .keyThreshold(keyThreshold),
      .detectThreshold(detectThreshold), .dwellCycles(dwellCycles), .hopMode(hopMode), .setups(setups));
   host_model u_host_model (.clk(clk), .setupRdData(setupRdData), .setupRdHit(setupRdHit), .setupAddr(setupAddr),
      .setupWrData(setupWrData), .setupWr(setupWr), .setupRd(setupRd), .hostBusy(hostBusy));

   always #25 clk = ~clk;
   // ==========================================
   // checking helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic expHit);
      logic [7:0] d;
      logic       h;
      u_host_model.get(a, d, h);
      check(d, exp);
      check(h, expHit);
   endtask
   task automatic refPulse(input logic [4:0] k, input logic [10:0] v);
      refSample = {1'b1, k, v};
      @(negedge clk);
      refSample = '0;
   endtask
   task automatic gainPulse(input logic [4:0] k, input logic [10:0] n, input logic [10:0] v);
      normalSignal = n;
      testSample = {1'b1, k, v};
      @(negedge clk);
      testSample = '0;
   endtask
   // interrupted burst; counts restart pulses shortly after the host lets go
   task automatic interrupted();
      burstActive = 1'b1;
      u_host_model.traffic(3);
      check(burstPause, 1'b1);
      seen = 0;
      repeat (3) begin
         @(negedge clk);
         if (burstRestart !== 1'b0) seen++;
      end
      check(burstPause, 1'b0);
      burstActive = 1'b0;
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================
   // hang guard
   initial begin
      #2000000;
      failures++;
      summarize();
   end
   // ==========================================
   // main sequence
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      burstActive = 1'b0;
      burstKey = 5'h00;
      refSample = '0;
      testSample = '0;
      statusClear = 1'b0;
      normalSignal = 11'h000;
      keyThreshold = 5'h12;
      failures = 0;
      testsRun = 0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      rd(8'hF1, 8'hC0, 1'b1);
      rd(8'hF2, 8'h64, 1'b1);
      rd(8'hF3, 8'h60, 1'b1);
      rd(8'hF4, 8'hC0, 1'b1);
      rd(8'hF5, 8'h00, 1'b0);
      check(dwellCycles, 7'h03);
      check(detectThreshold, 8'h12);
      // every code of the 244 fields
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         u_host_model.put(8'hF4, {c[1:0], c[1:0], c[0], c});
         @(negedge clk);
         check(hopMode, c[1:0]);
         check(dwellCycles, (125 + 625 * i + 49) / 50);
         check(detectThreshold, 8'h12 << c[1:0]);
         check(setups.restartInterruptedBurst, c[0]);
      end
      // bottom of the x8 range
      keyThreshold = 5'h04;
      @(negedge clk);
      check(detectThreshold, 8'h20);
      keyThreshold = 5'h12;
      u_host_model.put(8'hF3, 8'hFF);
      rd(8'hF3, 8'hF7, 1'b1);
      // sync on key 5, then selector 31 must stay silent
      u_host_model.put(8'hF1, 8'h28);
      burstKey = 5'h05;
      burstActive = 1'b1;
      @(negedge clk);
      check(syncPulse, 1'b1);
      burstKey = 5'h04;
      @(negedge clk);
      check(syncPulse, 1'b0);
      u_host_model.put(8'hF1, 8'hF8);
      burstKey = 5'h1F;
      repeat (2) @(negedge clk);
      check(syncPulse, 1'b0);
      burstActive = 1'b0;
      // limit 256 split over two bytes
      u_host_model.put(8'hF2, 8'h00);
      u_host_model.put(8'hF3, 8'h01);
      refPulse(5'h05, 11'h0FF);
      refPulse(5'h06, 11'h100);
      refPulse(5'h1E, 11'h000);
      check(keyLimitError, 24'h000020);
      check(statusLimitError, 1'b1);
      check(setups.lowerSignalLimit, 11'h100);
      statusClear = 1'b1;
      @(negedge clk);
      statusClear = 1'b0;
      check({statusLimitError, keyLimitError}, 25'h0);
      // a new error in the clear cycle must survive the clear
      statusClear = 1'b1;
      refPulse(5'h03, 11'h000);
      statusClear = 1'b0;
      check({statusLimitError, keyLimitError}, 25'h1000008);
      // gain threshold sweep at the pass boundary
      for (int i = 0; i < 16; i++) begin
         thr = 7'h04 + 7'h04 * i[6:0];
         u_host_model.put(8'hF3, {i[3:0], 4'h1});
         gainPulse(5'h01, 11'h0C8, 11'h0C8 - {4'h0, thr} - 11'h001);
         check(gainPass[1], 1'b1);
         gainPulse(5'h01, 11'h0C8, 11'h0C8 - {4'h0, thr});
         check(gainPass[1], 1'b0);
      end
      gainPulse(5'h02, 11'h00A, 11'h014);
      check(gainPass[2], 1'b0);
      // interrupted bursts with and without restart
      u_host_model.put(8'hF4, 8'h08);
      interrupted();
      check(seen, 1);
      u_host_model.put(8'hF4, 8'h00);
      interrupted();
      check(seen, 0);
      // selector off for production
      u_host_model.put(8'hF1, 8'hC0);
      rd(8'hF1, 8'hC0, 1'b1);
      // reset in mid-run brings the defaults back
      @(negedge clk);
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      rd(8'hF2, 8'h64, 1'b1);
      rd(8'hF4, 8'hC0, 1'b1);
      check(hopMode, 2'h3);
      check(setups.lowerSignalLimit, 11'd100);
      check(setups.scopeSyncKeySelect, 5'd24);
      check(setups.gainTestThreshold, 4'h6);
      summarize();
   end
endmodule
`default_nettype wire
